// *** iam_defs.svh ***
// Constants of the indirect access and interrupt mask register bank.
// Assumes inclusion by bare name from package and design files alike.
`ifndef IAM_DEFS_SVH
`define IAM_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices; byte address on the bus is four times the index
// ----------------------------------------------------------------------
`define IAM_IDX_MSR 14'h0002
`define IAM_IDX_LOW 14'h0004
`define IAM_IDX_CMD 14'h0006
`define IAM_IDX_DATA 14'h0008
`define IAM_IDX_IEN 14'h000a
`define IAM_IDX_REVISION 14'h000c

// ----------------------------------------------------------------------
// Field positions of the indirect command and status registers
// ----------------------------------------------------------------------
`define IAM_HI_ADDR_MSB 4
`define IAM_HI_ADDR_LSB 0
`define IAM_EXT_BIT 5
`define IAM_DIR_BIT 6
`define IAM_ACT_BIT 7
`define IAM_CSE_BIT 8
`define IAM_SRV_HOST_BIT 8
`define IAM_SRV_MSB 8

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IAM_LAW_RST 15'h0000
`define IAM_HI_ADDR_RST 5'h00
`define IAM_DATA_RST 16'h0000
`define IAM_IEN_RST 9'h000
// Arbitrary revision word, not tied to any real silicon
`define IAM_REVISION_DEFAULT 16'h00a5

`endif

// *** iam_pkg.sv ***
// Types shared by the indirect access register bank and its helpers.
// Assumes iam_defs.svh is on the include path.
`default_nettype none
package iam_pkg;

  // --------------------------------------------------------------------
  // Indirect cycle sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    IAM_IDLE,
    IAM_INT_WR,
    IAM_INT_RD,
    IAM_INT_CAP,
    IAM_EXT
  } iam_state_e;

  // --------------------------------------------------------------------
  // External memory request and answer
  // --------------------------------------------------------------------
  typedef struct packed {
    logic req;
    logic rd;
    logic [20:0] addr;
    logic [15:0] wdata;
  } iam_xreq_s;

  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } iam_xrsp_s;

endpackage
`default_nettype wire

// *** iam_mem.sv ***
// Internal word memory reached by indirect cycles.
// Assumes one clock; read data appear one enabled edge after the strobe.
`timescale 1ns/1ps
`default_nettype none
module iam_mem
  import iam_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // ----------------------------------------------------------------------
  // Storage, no reset so it maps onto a RAM
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_r <= '0;
    end else if (ce && re) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;

endmodule
`default_nettype wire

// *** iam_irq.sv ***
// Interrupt gate: service requests masked by enables onto one pin.
// Assumes request and enable vectors are synchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module iam_irq
  import iam_pkg::*;
#(
  parameter int NSRC = 9
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [NSRC-1:0] srv,
  input wire logic [NSRC-1:0] en,
  output logic irq
);

  logic irq_r;
  logic [NSRC-1:0] hit;

  // ----------------------------------------------------------------------
  // Per-source gating
  // ----------------------------------------------------------------------
  genvar g;
  for (g = 0; g < NSRC; g++) begin : gate_g
    assign hit[g] = srv[g] & en[g];
  end

  // Level output, drops once nothing enabled is pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |hit;
    end
  end

  assign irq = irq_r;

  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> irq == |($past(srv) & $past(en)))
    else $error("irq does not follow enabled requests");
  irq_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ce && (srv & en) == '0) |=> !irq)
    else $error("irq held with no enabled request");
  irq_rise_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));

endmodule
`default_nettype wire

// *** iam_top.sv ***
// Indirect memory access and interrupt mask register bank, AHB-Lite slave.
// Assumes single-word AHB-Lite transfers and module requests on hclk.
// Notes on behaviour
// - command bits 4:0 give address bits 20:16
// - bit 5 picks external memory, else internal
// - direction 0 writes data register to memory
// - direction 1 loads memory word into data register
// - writing active bit starts; hardware clears when done
// - software writing zero to active bit ignored
// - own registers stay reachable during a cycle
// - completion enable plus idle raises host request
// - nine enable bits, upper bits read zero
// - interrupt when enabled request is pending
// - low address bits 15:1, bit 0 reads zero
// - status shows nine requests matching enable positions
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "iam_defs.svh"
module iam_top
  import iam_pkg::*;
#(
  parameter int MEM_AW = 8,
  parameter logic [15:0] REVISION = `IAM_REVISION_DEFAULT // Arbitrary value
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] srv_req,
  output iam_xreq_s xreq,
  input wire iam_xrsp_s xrsp,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Bus state
  // ----------------------------------------------------------------------
  logic [13:0] idx_r;
  logic map_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic rd_ok_r;
  logic [31:0] hrdata_r;

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [14:0] law_r;
  logic [4:0] hi_addr_r;
  logic ext_sel_r;
  logic dir_rd_r;
  logic cse_r;
  logic [15:0] data_r;
  logic [8:0] ien_r;

  // ----------------------------------------------------------------------
  // Indirect cycle state
  // ----------------------------------------------------------------------
  iam_state_e st_r;
  iam_state_e st_nxt;
  logic [20:0] tgt_r;
  logic tgt_ext_r;
  logic tgt_rd_r;
  iam_xreq_s xreq_r;
  logic [15:0] mem_rdata;

  // ----------------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------------
  wire addr_take = ce & hsel & htrans[1] & hready;
  wire addr_map = (haddr[31:16] == 16'h0000) & (haddr[1:0] == 2'b00);

  // Data phase register selects
  wire sel_msr = map_r & (idx_r == `IAM_IDX_MSR);
  wire sel_low = map_r & (idx_r == `IAM_IDX_LOW);
  wire sel_cmd = map_r & (idx_r == `IAM_IDX_CMD);
  wire sel_data = map_r & (idx_r == `IAM_IDX_DATA);
  wire sel_ien = map_r & (idx_r == `IAM_IDX_IEN);
  wire sel_revision = map_r & (idx_r == `IAM_IDX_REVISION);

  // Write strobes, taken in the first data phase cycle
  wire wr_go = ce & wr_pend_r;
  wire wr_low = wr_go & sel_low;
  wire wr_cmd = wr_go & sel_cmd;
  wire wr_data = wr_go & sel_data;
  wire wr_ien = wr_go & sel_ien;

  // ----------------------------------------------------------------------
  // Status and command views
  // ----------------------------------------------------------------------
  wire cycle_active = (st_r != IAM_IDLE);
  wire host_service_request = cse_r & ~cycle_active;
  wire [8:0] srv_vec = {host_service_request, srv_req};
  wire [15:0] cmd_view = {7'h00, cse_r, cycle_active, dir_rd_r, ext_sel_r, hi_addr_r};
  wire start_go = wr_cmd & hwdata[`IAM_ACT_BIT] & ~cycle_active;

  // Read value mux, unmapped reads give zero
  wire [15:0] rd_val =
    sel_msr ? {7'h00, srv_vec} :
    sel_low ? {law_r, 1'b0} :
    sel_cmd ? cmd_view :
    sel_data ? data_r :
    sel_ien ? {7'h00, ien_r} :
    sel_revision ? REVISION : 16'h0000;

  // ----------------------------------------------------------------------
  // Sequencer completion and memory strobes
  // ----------------------------------------------------------------------
  wire ext_done = (st_r == IAM_EXT) & xrsp.ack;
  wire cyc_done = ce & ((st_r == IAM_INT_WR) | (st_r == IAM_INT_CAP) | ext_done);
  wire mem_we = (st_r == IAM_INT_WR);
  wire mem_re = (st_r == IAM_INT_RD);
  wire cap_int = ce & (st_r == IAM_INT_CAP) & tgt_rd_r;
  wire cap_ext = ce & ext_done & tgt_rd_r;

  // Reads take one wait state so a preceding write has landed
  assign hreadyout = ce & ~(rd_pend_r & ~rd_ok_r);
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign xreq = xreq_r;

  // ----------------------------------------------------------------------
  // Bus pipeline registers
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r <= '0;
      map_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else if (ce && hready) begin
      idx_r <= haddr[15:2];
      map_r <= addr_map;
      wr_pend_r <= addr_take & hwrite;
      rd_pend_r <= addr_take & ~hwrite;
    end
  end

  // Read data capture during the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ok_r <= 1'b0;
      hrdata_r <= '0;
    end else if (ce) begin
      rd_ok_r <= rd_pend_r & ~rd_ok_r;
      if (rd_pend_r && !rd_ok_r) begin
        hrdata_r <= {16'h0000, rd_val};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Address and command fields stay writable while a cycle runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      law_r <= `IAM_LAW_RST;
      hi_addr_r <= `IAM_HI_ADDR_RST;
      ext_sel_r <= 1'b0;
      dir_rd_r <= 1'b0;
      cse_r <= 1'b0;
    end else begin
      if (wr_low) begin
        law_r <= hwdata[15:1];
      end
      if (wr_cmd) begin
        hi_addr_r <= hwdata[`IAM_HI_ADDR_MSB:`IAM_HI_ADDR_LSB];
        ext_sel_r <= hwdata[`IAM_EXT_BIT];
        dir_rd_r <= hwdata[`IAM_DIR_BIT];
        cse_r <= hwdata[`IAM_CSE_BIT];
      end
    end
  end

  // Enable mask, nine bits only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ien_r <= `IAM_IEN_RST;
    end else if (wr_ien) begin
      ien_r <= hwdata[8:0];
    end
  end

  // Data register; a completing read beats a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_r <= `IAM_DATA_RST;
    end else if (cap_int) begin
      data_r <= mem_rdata;
    end else if (cap_ext) begin
      data_r <= xrsp.rdata;
    end else if (wr_data) begin
      data_r <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // Indirect cycle sequencer
  // ----------------------------------------------------------------------
  // Target is latched at start so later command writes cannot disturb it
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      IAM_IDLE: begin
        if (start_go) begin
          if (hwdata[`IAM_EXT_BIT]) begin
            st_nxt = IAM_EXT;
          end else if (hwdata[`IAM_DIR_BIT]) begin
            st_nxt = IAM_INT_RD;
          end else begin
            st_nxt = IAM_INT_WR;
          end
        end
      end
      IAM_INT_WR: st_nxt = IAM_IDLE;
      IAM_INT_RD: st_nxt = IAM_INT_CAP;
      IAM_INT_CAP: st_nxt = IAM_IDLE;
      IAM_EXT: begin
        if (xrsp.ack) begin
          st_nxt = IAM_IDLE;
        end
      end
      default: st_nxt = IAM_IDLE;
    endcase
  end

  // Zero written to the active bit has no path to clear the state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= IAM_IDLE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // Latched target address and kind
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tgt_r <= '0;
      tgt_ext_r <= 1'b0;
      tgt_rd_r <= 1'b0;
    end else if (start_go) begin
      tgt_r <= {hwdata[`IAM_HI_ADDR_MSB:`IAM_HI_ADDR_LSB], law_r, 1'b0};
      tgt_ext_r <= hwdata[`IAM_EXT_BIT];
      tgt_rd_r <= hwdata[`IAM_DIR_BIT];
    end
  end

  // External request held until the memory answers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xreq_r <= '0;
    end else if (start_go && hwdata[`IAM_EXT_BIT]) begin
      xreq_r.req <= 1'b1;
      xreq_r.rd <= hwdata[`IAM_DIR_BIT];
      xreq_r.addr <= {hwdata[`IAM_HI_ADDR_MSB:`IAM_HI_ADDR_LSB], law_r, 1'b0};
      xreq_r.wdata <= data_r;
    end else if (ext_done && ce) begin
      xreq_r.req <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Internal memory and interrupt gate
  // ----------------------------------------------------------------------
  iam_mem #(
    .AW(MEM_AW),
    .DW(16)
  ) u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .we(mem_we),
    .re(mem_re),
    .addr(tgt_r[MEM_AW:1]),
    .wdata(data_r),
    .rdata(mem_rdata)
  );

  iam_irq #(
    .NSRC(9)
  ) u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .srv(srv_vec),
    .en(ien_r),
    .irq(irq)
  );

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  start_sets_a: assert property (start_go |=> cycle_active)
    else $error("start did not raise cycle active");
  zero_write_a: assert property (
    (wr_cmd && !hwdata[`IAM_ACT_BIT] && cycle_active && !cyc_done) |=> cycle_active)
    else $error("software zero cleared cycle active");
  high_addr_a: assert property (
    start_go |=> tgt_r[20:16] == $past(hwdata[`IAM_HI_ADDR_MSB:`IAM_HI_ADDR_LSB]))
    else $error("high address bits not applied");
  ext_route_a: assert property ((st_r == IAM_EXT) |-> xreq_r.req && tgt_ext_r)
    else $error("external cycle without request");
  int_write_a: assert property (mem_we |-> !tgt_rd_r && !tgt_ext_r)
    else $error("internal write with wrong direction");
  int_read_a: assert property (cap_int |=> data_r == $past(mem_rdata))
    else $error("read data not loaded");
  host_srv_a: assert property (
    (cyc_done && cse_r && !wr_cmd) |=> srv_vec[`IAM_SRV_HOST_BIT])
    else $error("host request missing at completion");
  busy_bus_a: assert property (
    (cycle_active && rd_pend_r && !rd_ok_r && ce) |=> ce |-> hreadyout)
    else $error("register read stalled by indirect cycle");
  ien_upper_a: assert property ((rd_ok_r && sel_ien) |-> hrdata_r[31:9] == '0)
    else $error("enable register upper bits not zero");
  law_bit0_a: assert property ((rd_ok_r && sel_low) |-> !hrdata_r[0])
    else $error("low address bit 0 not zero");
  msr_view_a: assert property ((rd_ok_r && sel_msr) |-> hrdata_r[8:0] == $past(srv_vec))
    else $error("status does not show requests");

  int_wr_c: cover property (st_r == IAM_INT_WR);
  int_rd_c: cover property (cap_int);
  ext_rd_c: cover property (cap_ext);
  busy_read_c: cover property (cycle_active && rd_ok_r);

endmodule
`default_nettype wire

// *** iam_top_tb.sv ***
// Self-checking bench for the indirect access and interrupt mask bank.
// Assumes iam_pkg and iam_defs.svh are compiled first; one hclk domain.
`timescale 1ns/1ps
`default_nettype none
`include "iam_defs.svh"
module iam_top_tb
  import iam_pkg::*;
;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  localparam int AW = 4; // Small memory so every word gets touched
  localparam logic [15:0] REVISION_T = 16'h3c96; // Arbitrary revision value
  localparam logic [31:0] A_MSR = {16'h0, `IAM_IDX_MSR, 2'b00};
  localparam logic [31:0] A_LOW = {16'h0, `IAM_IDX_LOW, 2'b00};
  localparam logic [31:0] A_CMD = {16'h0, `IAM_IDX_CMD, 2'b00};
  localparam logic [31:0] A_DATA = {16'h0, `IAM_IDX_DATA, 2'b00};
  localparam logic [31:0] A_IEN = {16'h0, `IAM_IDX_IEN, 2'b00};
  localparam logic [31:0] A_REVISION = {16'h0, `IAM_IDX_REVISION, 2'b00};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] srv_req = 8'h00;
  iam_xrsp_s xrsp = '0;
  iam_xreq_s xreq;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int x_wait = 0;
  int x_delay = 0;
  logic [15:0] lfsr = 16'h3efb;
  logic [20:0] x_addr;
  logic x_rd;
  logic [15:0] x_wdata;
  logic [15:0] mem_ref [16];

  iam_top #(.MEM_AW(AW), .REVISION(REVISION_T)) iam_top_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .srv_req(srv_req), .xreq(xreq), .xrsp(xrsp), .irq(irq));

  always #2.5 hclk = ~hclk;

  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge hclk) begin
    cycles++;
    if (cycles > 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  // External memory responder; slow or quick as x_delay says
  always @(posedge hclk) begin
    if (xreq.req && !xrsp.ack && x_wait >= x_delay) begin
      xrsp.ack <= 1'b1;
      xrsp.rdata <= ext_val(xreq.addr);
      x_addr <= xreq.addr;
      x_rd <= xreq.rd;
      x_wdata <= xreq.wdata;
      x_wait <= 0;
    end else begin
      xrsp.ack <= 1'b0;
      xrsp.rdata <= ~xrsp.rdata; // Stale data must never look valid
      if (xreq.req) begin
        x_wait <= x_wait + 1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  function automatic logic [15:0] ext_val(input logic [20:0] a);
    return a[15:0] ^ {a[20:16], 11'h2a5};
  endfunction

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One single AHB-Lite transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [15:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic chk_rd(input logic [31:0] a, input logic [15:0] e, input string nm);
    logic [31:0] x;
    bus(1'b0, a, 16'h0, x);
    check(nm, {16'h0, e}, x);
    check("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic wait_idle();
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      bus(1'b0, A_CMD, 16'h0, v);
      n++;
    end while (v[7] !== 1'b0 && n < 100);
    check("cycle_active", 32'h0, {31'h0, v[7]});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [15:0] r;
    logic [15:0] low_address_bits;
    logic [4:0] hi;
    logic [8:0] m;
    logic [7:0] s;
    logic rw;
    logic cse;
    int i;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, reserved bits and unmapped places
    chk_rd(A_MSR, 16'h0, "status");
    chk_rd(A_CMD, 16'h0, "command");
    chk_rd(A_IEN, 16'h0, "enables");
    chk_rd(A_REVISION, REVISION_T, "revision");
    wr(A_LOW, 16'hffff);
    chk_rd(A_LOW, 16'hfffe, "low_addr");
    wr(A_IEN, 16'hffff);
    chk_rd(A_IEN, 16'h01ff, "enables");
    wr(A_REVISION, 16'h0000);
    chk_rd(A_REVISION, REVISION_T, "revision");
    wr(A_CMD, 16'hff7f);
    chk_rd(A_CMD, 16'h017f, "command");
    wr(A_CMD, 16'h0000);
    wr(32'h0000_0034, 16'hffff);
    chk_rd(32'h0000_0034, 16'h0, "unmapped");
    chk_rd(32'h0001_0010, 16'h0, "unmapped");
    $display("test registers done");
    // Internal memory: fill every word, then read back at random
    for (i = 0; i < 16; i++) begin
      d = rnd();
      mem_ref[i] = d;
      r = rnd();
      low_address_bits = {r[15:5], i[3:0], 1'b0};
      wr(A_DATA, d);
      wr(A_LOW, low_address_bits);
      r = rnd();
      wr(A_CMD, {8'h00, 3'b100, r[4:0]});
      wait_idle();
    end
    for (i = 0; i < 16; i++) begin
      d = rnd();
      r = rnd();
      wr(A_LOW, {r[15:5], d[3:0], 1'b0});
      r = rnd();
      wr(A_CMD, {8'h00, 3'b110, r[4:0]});
      wait_idle();
      chk_rd(A_DATA, mem_ref[d[3:0]], "internal_read");
    end
    $display("test internal done");
    // External memory, slow answers first so the busy window is visible
    for (i = 0; i < 8; i++) begin
      r = rnd();
      hi = r[4:0];
      low_address_bits = rnd() & 16'hfffe;
      d = rnd();
      rw = i[0];
      r = rnd();
      x_delay = (i < 2) ? 14 : int'(r[1:0]);
      wr(A_DATA, d);
      wr(A_LOW, low_address_bits);
      wr(A_CMD, {7'h00, 2'b11, rw, 1'b1, hi});
      if (i < 2) begin
        chk_rd(A_CMD, {7'h00, 2'b11, rw, 1'b1, hi}, "busy_cmd");
        chk_rd(A_MSR, 16'h0000, "busy_status");
        wr(A_CMD, {7'h00, 2'b10, rw, 1'b1, hi});
        chk_rd(A_CMD, {7'h00, 2'b11, rw, 1'b1, hi}, "zero_write");
      end
      wait_idle();
      check("ext_addr", {11'h0, hi, low_address_bits}, {11'h0, x_addr});
      check("ext_dir", {31'h0, rw}, {31'h0, x_rd});
      if (!rw) begin
        check("ext_wdata", {16'h0, d}, {16'h0, x_wdata});
      end else begin
        chk_rd(A_DATA, ext_val({hi, low_address_bits}), "ext_read");
      end
      chk_rd(A_MSR, 16'h0100, "done_status");
    end
    $display("test external done");
    // Interrupt gating over random requests and enables
    for (i = 0; i < 24; i++) begin
      r = rnd();
      s = (i == 1) ? 8'h00 : r[7:0];
      r = rnd();
      m = (i == 0) ? 9'h000 : r[8:0];
      cse = i[2];
      srv_req <= s;
      wr(A_IEN, {7'h00, m});
      wr(A_CMD, {7'h00, cse, 8'h00});
      repeat (2) @(posedge hclk);
      check("irq", {31'h0, |({cse, s} & m)}, {31'h0, irq});
      chk_rd(A_MSR, {7'h00, cse, s}, "status_flags");
    end
    // Clear the host flag so only module requests drive the pin
    wr(A_CMD, 16'h0000);
    wr(A_IEN, 16'h00ff);
    srv_req <= 8'h01;
    repeat (2) @(posedge hclk);
    // Clock enable low freezes the pin although the request went away
    ce <= 1'b0;
    srv_req <= 8'h00;
    repeat (3) @(posedge hclk);
    check("irq_frozen", 32'h1, {31'h0, irq});
    ce <= 1'b1;
    repeat (3) @(posedge hclk);
    check("irq_drop", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    end_of_test();
  end
endmodule
`default_nettype wire
